// ### src/bpc_regs.sv
`timescale 1ns/1ps
module bpc_regs #(
  parameter int unsigned UV_DGT_BASE_CYC = bpc_pkg::UV_DGT_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port from the serial management slave
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // measurements on this clock
  input wire logic [11:0] therm_volt_mv,
  input wire logic [1:0] therm_bias_sel,
  input wire logic [12:0] batt_mv,
  // asynchronous comparator pins
  input wire logic ov_chg_det,
  input wire logic oc_chg_det,
  input wire logic oc_dis_det,
  // factory trim pins
  input wire logic trim_prot_en,
  input wire logic [3:0] trim_uv_thr,
  // protection outputs
  output logic isolation_switch_on,
  output logic charge_allow,
  output logic chg_oc_off,
  output logic dis_oc_off,
  output logic uv_fault,
  output logic [5:0] therm_bias_ua
);
  import bpc_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] uv_set_q;
  logic [7:0] reg_rdata_q;
  logic reg_ack_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [1:0] boot_cnt_q;
  logic iso_on_q;
  logic chg_allow_q;
  logic [5:0] bias_ua_q;
  logic [1:0] oc_off;

  bpc_uv_if uv_bus ();

  // pins pass two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {trim_uv_thr, trim_prot_en, oc_dis_det, oc_chg_det, ov_chg_det};
      sync2_q <= sync1_q;
    end
  end

  wire ov_s = sync2_q[0];
  wire [1:0] oc_s = sync2_q[2:1];
  wire trim_en_s = sync2_q[3];
  wire [3:0] trim_thr_s = sync2_q[7:4];

  // factory values are caught once the synchronisers have settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_cnt_q <= '0;
    end else if (boot_cnt_q != BOOT_DONE_CNT) begin
      boot_cnt_q <= boot_cnt_q + 1'b1;
    end
  end

  wire strap_load = (boot_cnt_q == STRAP_LOAD_CNT);

  // address decode
  wire sel_lo = (reg_addr == ADDR_TV_LOW);
  wire sel_up = (reg_addr == ADDR_TV_UP);
  wire sel_ctrl = (reg_addr == ADDR_CTRL);
  wire sel_uv = (reg_addr == ADDR_UV);
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_uv = reg_wr && sel_uv;

  wire [7:0] ctrl_wr_val = reg_wdata & CTRL_WMASK;
  wire [7:0] ctrl_nx = wr_ctrl ? ctrl_wr_val : ctrl_q;
  wire [7:0] ctrl_d = strap_load ? {ctrl_nx[7:1], trim_en_s} : ctrl_nx;
  wire [7:0] uv_nx = wr_uv ? reg_wdata : uv_set_q;
  wire [7:0] uv_d = strap_load ? {trim_thr_s, uv_nx[3:0]} : uv_nx;

  wire [7:0] rd_up = {4'h0, therm_volt_mv[11:8]};
  wire [7:0] rd_lo = therm_volt_mv[7:0];
  wire [7:0] rd_mux = sel_lo ? rd_lo :
                      sel_up ? rd_up :
                      sel_ctrl ? ctrl_q :
                      sel_uv ? uv_set_q : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      uv_set_q <= UV_RST;
    end else begin
      ctrl_q <= ctrl_d;
      uv_set_q <= uv_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
      reg_ack_q <= 1'b0;
    end else begin
      reg_ack_q <= reg_wr || reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  wire prot_en = ctrl_q[CTRL_EN_BIT];

  assign uv_bus.en = prot_en;
  assign uv_bus.thr_code = uv_set_q[UV_THR_LSB +: 4];
  assign uv_bus.hys_code = uv_set_q[UV_HYS_LSB +: 2];
  assign uv_bus.dgt_code = uv_set_q[UV_DGT_LSB +: 2];
  assign uv_bus.batt_mv = batt_mv;

  bpc_uv_qual #(
    .DGT_BASE_CYC(UV_DGT_BASE_CYC)
  ) u_uv (
    .clk(clk),
    .nrst(nrst),
    .uv(uv_bus)
  );

  // one guard per direction, charge then discharge
  for (genvar i = 0; i < 2; i++) begin : g_oc
    bpc_oc_guard u_oc (
      .clk(clk),
      .nrst(nrst),
      .en(prot_en),
      .hiccup(ctrl_q[CTRL_COC_BIT + i]),
      .det(oc_s[i]),
      .off(oc_off[i])
    );
  end

  wire iso_on_d = !(prot_en && ov_s && ctrl_q[CTRL_ISO_BIT]);
  wire chg_allow_d = !(prot_en && uv_bus.fault && !ctrl_q[CTRL_CHGUV_BIT]);
  wire [5:0] bias_ua_d = (therm_bias_sel == 2'h0) ? BIAS_60_UA :
                         (therm_bias_sel == 2'h1) ? BIAS_12_UA : BIAS_6_UA;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      iso_on_q <= 1'b1;
      chg_allow_q <= 1'b1;
      bias_ua_q <= BIAS_60_UA;
    end else begin
      iso_on_q <= iso_on_d;
      chg_allow_q <= chg_allow_d;
      bias_ua_q <= bias_ua_d;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_ack = reg_ack_q;
  assign isolation_switch_on = iso_on_q;
  assign charge_allow = chg_allow_q;
  assign chg_oc_off = oc_off[0];
  assign dis_oc_off = oc_off[1];
  assign uv_fault = uv_bus.fault;
  assign therm_bias_ua = bias_ua_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_rd_up;
    reg_rd && reg_addr == ADDR_TV_UP |=> reg_ack && reg_rdata == {4'h0, $past(therm_volt_mv[11:8])};
  endproperty
  a_rd_up: assert property (p_rd_up) else $error("upper nibble readback wrong");

  property p_rd_lo;
    reg_rd && reg_addr == ADDR_TV_LOW |=> reg_rdata == $past(therm_volt_mv[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("lower byte readback wrong");

  property p_bias;
    therm_bias_sel == 2'h0 |=> therm_bias_ua == 6'h3c;
  endproperty
  a_bias: assert property (p_bias) else $error("bias code 00 not 60 uA");

  property p_iso;
    ov_chg_det ##2 prot_en && ctrl_q[CTRL_ISO_BIT] |=> !isolation_switch_on;
  endproperty
  a_iso: assert property (p_iso) else $error("isolation switch not off on overvoltage");

  property p_chg_uv;
    prot_en && uv_bus.fault && !ctrl_q[CTRL_CHGUV_BIT] |=> !charge_allow;
  endproperty
  a_chg_uv: assert property (p_chg_uv) else $error("charge allowed in undervoltage");

  property p_disabled;
    !prot_en |=> isolation_switch_on && charge_allow;
  endproperty
  a_disabled: assert property (p_disabled) else $error("protection acts while disabled");

  property p_uv_wr;
    wr_uv && !strap_load |=> uv_set_q == $past(reg_wdata);
  endproperty
  a_uv_wr: assert property (p_uv_wr) else $error("undervoltage setting not stored");

  property p_resv;
    reg_rd && (sel_ctrl || sel_up) |=> reg_rdata[7:5] == 3'h0 ##1 ctrl_q[7:5] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

  property p_ctrl_wr;
    wr_ctrl && !strap_load |=> ctrl_q == ($past(reg_wdata) & CTRL_WMASK);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_up_resv;
    reg_rd && sel_up |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_up_resv: assert property (p_up_resv) else $error("upper nibble reserved bits set");

  property p_ro_wr;
    reg_wr && (sel_lo || sel_up) && !strap_load |=> $stable(ctrl_q) && $stable(uv_set_q);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write took effect");

  property p_iso_keep;
    !ctrl_q[CTRL_ISO_BIT] |=> isolation_switch_on;
  endproperty
  a_iso_keep: assert property (p_iso_keep) else $error("switch off with bit 4 low");

  property p_chg_ok;
    ctrl_q[CTRL_CHGUV_BIT] |=> charge_allow;
  endproperty
  a_chg_ok: assert property (p_chg_ok) else $error("charging blocked with bit 1 high");

  property p_oc_disabled;
    !prot_en |=> !chg_oc_off && !dis_oc_off;
  endproperty
  a_oc_disabled: assert property (p_oc_disabled) else $error("overcurrent off while disabled");

  property p_uv_disabled;
    !prot_en |=> !uv_fault;
  endproperty
  a_uv_disabled: assert property (p_uv_disabled) else $error("undervoltage fault while disabled");

  property p_bias_mid;
    therm_bias_sel == 2'h1 |=> therm_bias_ua == BIAS_12_UA;
  endproperty
  a_bias_mid: assert property (p_bias_mid) else $error("bias code 01 not 12 uA");

  property p_bias_low;
    therm_bias_sel[1] |=> therm_bias_ua == BIAS_6_UA;
  endproperty
  a_bias_low: assert property (p_bias_low) else $error("bias code 1x not 6 uA");

  property p_trim;
    strap_load |=> ctrl_q[CTRL_EN_BIT] == $past(trim_en_s) &&
      uv_set_q[UV_THR_LSB +: 4] == $past(trim_thr_s);
  endproperty
  a_trim: assert property (p_trim) else $error("factory values not captured");

  property p_rd_uv;
    reg_rd && sel_uv |=> reg_rdata == $past(uv_set_q);
  endproperty
  a_rd_uv: assert property (p_rd_uv) else $error("undervoltage readback wrong");

  property p_rd_ctrl;
    reg_rd && sel_ctrl |=> reg_rdata == $past(ctrl_q);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");

  property p_rd_none;
    reg_rd && !(sel_lo || sel_up || sel_ctrl || sel_uv) |=> reg_rdata == 8'h00;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");

  c_rd_ctrl: cover property (reg_rd && sel_ctrl ##1 reg_ack);
  c_iso_off: cover property ($fell(isolation_switch_on));
  c_chg_block: cover property ($fell(charge_allow));
endmodule : bpc_regs

// ### src/bpc_pkg.sv
package bpc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;

  // register offsets on the management port
  localparam logic [7:0] ADDR_TV_LOW = 8'h0f;
  localparam logic [7:0] ADDR_TV_UP = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h11;
  localparam logic [7:0] ADDR_UV = 8'h12;

  // control register field positions
  localparam int unsigned CTRL_ISO_BIT = 4;
  localparam int unsigned CTRL_DOC_BIT = 3;
  localparam int unsigned CTRL_COC_BIT = 2;
  localparam int unsigned CTRL_CHGUV_BIT = 1;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h1f;
  localparam logic [7:0] CTRL_RST = 8'h02;

  // undervoltage setting field positions
  localparam int unsigned UV_THR_LSB = 4;
  localparam int unsigned UV_HYS_LSB = 2;
  localparam int unsigned UV_DGT_LSB = 0;
  localparam logic [7:0] UV_RST = 8'h00;

  // undervoltage threshold scale
  localparam logic [12:0] UV_THR_BASE_MV = 13'h0802;
  localparam logic [12:0] UV_THR_STEP_MV = 13'h0032;
  localparam logic [6:0] UV_HYS_BASE_PCT = 7'h64;

  // deglitch base time, doubled per code step
  localparam int unsigned UV_DGT_BASE_MS = 30;
  localparam int unsigned UV_DGT_BASE_CYC = UV_DGT_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned UV_CNT_W = 25;

  // hiccup off time before an overcurrent retry
  localparam int unsigned HICCUP_OFF_US = 10;
  localparam int unsigned HICCUP_OFF_CYC = HICCUP_OFF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HICCUP_CNT_W = 10;

  // thermistor bias current in microamps
  localparam logic [5:0] BIAS_60_UA = 6'h3c;
  localparam logic [5:0] BIAS_12_UA = 6'h0c;
  localparam logic [5:0] BIAS_6_UA = 6'h06;

  // factory trim capture after reset release
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  localparam logic [1:0] BOOT_DONE_CNT = 2'h3;

  typedef enum logic [2:0] {
    OC_RUN = 3'b001,
    OC_TRIP = 3'b010,
    OC_WAIT = 3'b100
  } bpc_oc_state_t;
endpackage : bpc_pkg

// ### src/bpc_uv_if.sv
`timescale 1ns/1ps
interface bpc_uv_if;
  logic en;
  logic [3:0] thr_code;
  logic [1:0] hys_code;
  logic [1:0] dgt_code;
  logic [12:0] batt_mv;
  logic fault;

  modport ctl (output en, output thr_code, output hys_code, output dgt_code,
               output batt_mv, input fault);
  modport qual (input en, input thr_code, input hys_code, input dgt_code,
                input batt_mv, output fault);
endinterface : bpc_uv_if

// ### src/bpc_oc_guard.sv
`timescale 1ns/1ps
module bpc_oc_guard (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control and detector
  input wire logic en,
  input wire logic hiccup,
  input wire logic det,
  // switch off request
  output logic off
);
  import bpc_pkg::*;

  bpc_oc_state_t state_q, state_d;
  logic [HICCUP_CNT_W-1:0] cnt_q;
  logic off_q;
  wire cnt_end = (cnt_q == HICCUP_CNT_W'(HICCUP_OFF_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      OC_RUN: begin
        if (en && det) begin
          state_d = hiccup ? OC_WAIT : OC_TRIP;
        end
      end
      // latched off until protection is disabled
      OC_TRIP: begin
        if (!en) begin
          state_d = OC_RUN;
        end
      end
      OC_WAIT: begin
        if (!en || cnt_end) begin
          state_d = OC_RUN;
        end
      end
      default: state_d = OC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= OC_RUN;
      cnt_q <= '0;
      off_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == OC_WAIT) ? cnt_q + 1'b1 : '0;
      off_q <= (state_d != OC_RUN);
    end
  end

  assign off = off_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_oc_latch;
    state_q == OC_TRIP && en |=> state_q == OC_TRIP && off;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("latched trip released");

  // hiccup off time is tracked through the retry counter, step by step
  property p_oc_retry;
    $rose(state_q == OC_WAIT) |-> off && cnt_q == '0;
  endproperty
  a_oc_retry: assert property (p_oc_retry) else $error("hiccup retry timing wrong");

  property p_oc_step;
    state_q == OC_WAIT && en && cnt_q != HICCUP_CNT_W'(HICCUP_OFF_CYC - 1)
      |=> state_q == OC_WAIT && off && cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_oc_step: assert property (p_oc_step) else $error("hiccup wait cut short");

  property p_oc_end;
    state_q == OC_WAIT && cnt_q == HICCUP_CNT_W'(HICCUP_OFF_CYC - 1) |=> !off;
  endproperty
  a_oc_end: assert property (p_oc_end) else $error("hiccup wait not ended");

  c_oc_retry: cover property ($fell(state_q == OC_WAIT) && en);
endmodule : bpc_oc_guard

// ### src/bpc_uv_qual.sv
`timescale 1ns/1ps
module bpc_uv_qual #(
  parameter int unsigned DGT_BASE_CYC = bpc_pkg::UV_DGT_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // settings, voltage and fault
  bpc_uv_if.qual uv
);
  import bpc_pkg::*;

  logic [UV_CNT_W-1:0] cnt_q;
  logic fault_q;
  logic fault_d;

  wire [12:0] thr_mv = UV_THR_BASE_MV + 13'(UV_THR_STEP_MV * uv.thr_code);
  wire [6:0] hys_pct = 7'({uv.hys_code, 1'b0}) + 7'h02;
  wire [19:0] rel_prod = 20'(thr_mv) * 20'(UV_HYS_BASE_PCT + hys_pct);
  wire [12:0] rel_mv = 13'(rel_prod / 20'd100);
  wire [UV_CNT_W-1:0] dgt_lim = UV_CNT_W'(DGT_BASE_CYC) << uv.dgt_code;
  wire below = uv.batt_mv < thr_mv;
  wire above_rel = uv.batt_mv > rel_mv;
  wire qual_done = below && (cnt_q == dgt_lim - 1'b1);

  always_comb begin
    fault_d = fault_q;
    if (!uv.en) begin
      fault_d = 1'b0;
    end else if (!fault_q && qual_done) begin
      fault_d = 1'b1;
    end else if (fault_q && above_rel) begin
      fault_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      fault_q <= 1'b0;
    end else begin
      cnt_q <= (uv.en && !fault_q && below && !qual_done) ? cnt_q + 1'b1 : '0;
      fault_q <= fault_d;
    end
  end

  assign uv.fault = fault_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_uv_qual;
    $rose(fault_q) |-> $past(below) && $past(cnt_q) == $past(dgt_lim) - 1'b1;
  endproperty
  a_uv_qual: assert property (p_uv_qual) else $error("fault before deglitch end");

  property p_uv_hold;
    !fault_q && !below |=> !fault_q;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("fault set above threshold");

  property p_uv_hys;
    fault_q && uv.en && !above_rel |=> fault_q;
  endproperty
  a_uv_hys: assert property (p_uv_hys) else $error("fault released inside hysteresis");

  c_uv_rise: cover property ($rose(fault_q));
endmodule : bpc_uv_qual

// ### bench/tb_bpc_regs.sv
`timescale 1ns/1ps
module tb_bpc_regs;
  import bpc_pkg::*;

  localparam int unsigned DGT_CYC = 20;

  logic clk;
  logic nrst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic [11:0] therm_volt_mv;
  logic [1:0] therm_bias_sel;
  logic [12:0] batt_mv;
  logic ov_chg_det;
  logic oc_chg_det;
  logic oc_dis_det;
  logic trim_prot_en;
  logic [3:0] trim_uv_thr;
  logic isolation_switch_on;
  logic charge_allow;
  logic chg_oc_off;
  logic dis_oc_off;
  logic uv_fault;
  logic [5:0] therm_bias_ua;
  int n_fail;
  int check_count;
  logic [7:0] ctl;
  logic [5:0] bias_exp [4];

  bpc_regs #(.UV_DGT_BASE_CYC(DGT_CYC)) i_bpc_regs (
    .clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .therm_volt_mv(therm_volt_mv), .therm_bias_sel(therm_bias_sel), .batt_mv(batt_mv),
    .ov_chg_det(ov_chg_det), .oc_chg_det(oc_chg_det), .oc_dis_det(oc_dis_det),
    .trim_prot_en(trim_prot_en), .trim_uv_thr(trim_uv_thr),
    .isolation_switch_on(isolation_switch_on), .charge_allow(charge_allow),
    .chg_oc_off(chg_oc_off), .dis_oc_off(dis_oc_off), .uv_fault(uv_fault),
    .therm_bias_ua(therm_bias_ua)
  );

  always #5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("counts: %0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, n_fail);
  endtask : done

  // wait whole cycles, then sample once the edge has settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    check({15'h0, reg_ack}, 16'h1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({15'h0, reg_ack}, 16'h1);
    check({8'h0, reg_rdata}, {8'h0, exp});
  endtask : rd

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    therm_volt_mv = 12'habc;
    therm_bias_sel = 2'h0;
    batt_mv = 13'h0fa0;
    ov_chg_det = 1'b0;
    oc_chg_det = 1'b0;
    oc_dis_det = 1'b0;
    trim_prot_en = 1'b1;
    trim_uv_thr = 4'h3;
    n_fail = 0;
    check_count = 0;
    bias_exp = '{6'h3c, 6'h0c, 6'h06, 6'h06};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);

    // reset values with factory trim folded in
    rd(ADDR_CTRL, 8'h03);
    rd(ADDR_UV, 8'h30);
    done("reset");

    // thermistor readback and bias current codes
    rd(ADDR_TV_LOW, therm_volt_mv[7:0]);
    rd(ADDR_TV_UP, {4'h0, therm_volt_mv[11:8]});
    wr(ADDR_TV_UP, 8'hff);
    rd(ADDR_TV_UP, {4'h0, therm_volt_mv[11:8]});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      therm_bias_sel <= i[1:0];
      wait_n(3);
      check({10'h0, therm_bias_ua}, {10'h0, bias_exp[i]});
    end
    done("thermistor");

    // reserved bits, unmapped place
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, 8'h1f);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    done("access");

    // overvoltage response of the isolation switch
    for (int i = 0; i < 3; i++) begin
      ctl = (i == 0) ? 8'h11 : ((i == 1) ? 8'h01 : 8'h10);
      wr(ADDR_CTRL, ctl);
      @(posedge clk);
      ov_chg_det <= 1'b1;
      wait_n(6);
      check({15'h0, isolation_switch_on}, {15'h0, !(ctl[4] && ctl[0])});
      @(posedge clk);
      ov_chg_det <= 1'b0;
      wait_n(6);
    end
    done("overvoltage");

    // overcurrent latch and hiccup, both paths
    for (int k = 0; k < 4; k++) begin
      ctl = 8'h01 | (8'(k[0]) << (k[1] ? 3 : 2));
      wr(ADDR_CTRL, ctl);
      @(posedge clk);
      oc_chg_det <= !k[1];
      oc_dis_det <= k[1];
      wait_n(5);
      @(posedge clk);
      oc_chg_det <= 1'b0;
      oc_dis_det <= 1'b0;
      wait_n(5);
      check({15'h0, k[1] ? dis_oc_off : chg_oc_off}, 16'h1);
      wait_n(900);
      check({15'h0, k[1] ? dis_oc_off : chg_oc_off}, 16'h1);
      wait_n(200);
      check({15'h0, k[1] ? dis_oc_off : chg_oc_off}, {15'h0, !k[0]});
      wr(ADDR_CTRL, 8'h00);
      wait_n(5);
      check({14'h0, dis_oc_off, chg_oc_off}, 16'h0);
    end
    done("overcurrent");

    // undervoltage: 2150 mV, 4 percent, twice the base deglitch
    wr(ADDR_UV, 8'h25);
    rd(ADDR_UV, 8'h25);
    wr(ADDR_CTRL, 8'h01);
    @(posedge clk);
    batt_mv <= 13'd2150;
    wait_n(60);
    check({15'h0, uv_fault}, 16'h0);
    @(posedge clk);
    batt_mv <= 13'd2149;
    wait_n(30);
    check({15'h0, uv_fault}, 16'h0);
    wait_n(20);
    check({15'h0, uv_fault}, 16'h1);
    check({15'h0, charge_allow}, 16'h0);
    wr(ADDR_CTRL, 8'h03);
    wait_n(3);
    check({15'h0, charge_allow}, 16'h1);
    @(posedge clk);
    batt_mv <= 13'd2236;
    wait_n(6);
    check({15'h0, uv_fault}, 16'h1);
    @(posedge clk);
    batt_mv <= 13'd2237;
    wait_n(4);
    check({15'h0, uv_fault}, 16'h0);
    @(posedge clk);
    batt_mv <= 13'd2000;
    wait_n(50);
    check({15'h0, uv_fault}, 16'h1);
    wr(ADDR_CTRL, 8'h02);
    wait_n(3);
    check({15'h0, uv_fault}, 16'h0);
    // 2050 mV, 8 percent, eight times the base deglitch
    wr(ADDR_UV, 8'h0f);
    wr(ADDR_CTRL, 8'h01);
    @(posedge clk);
    batt_mv <= 13'd2049;
    wait_n(150);
    check({15'h0, uv_fault}, 16'h0);
    wait_n(20);
    check({15'h0, uv_fault}, 16'h1);
    @(posedge clk);
    batt_mv <= 13'd2214;
    wait_n(4);
    check({15'h0, uv_fault}, 16'h1);
    @(posedge clk);
    batt_mv <= 13'd2215;
    wait_n(4);
    check({15'h0, uv_fault}, 16'h0);
    done("undervoltage");
    end_of_test();
  end
endmodule : tb_bpc_regs
